// >>> design/dkra_defs.svh
`ifndef DKRA_DEFS_SVH
`define DKRA_DEFS_SVH

// Clock and tick periods in picoseconds
`define DKRA_CLK_PS          4000
`define DKRA_MS_PS           1000000000

// Pulse and window lengths in milliseconds
`define DKRA_T_KR_FIRST_MS   1000
`define DKRA_T_KR_HALF_MS    500
`define DKRA_T_CLOSE_WIN_MS  500
`define DKRA_T_GAP_MS        100
`define DKRA_T_CRASH_MS      5000
`define DKRA_T_AUTO_MS       500
`define DKRA_T_CENTRAL_MS    500

// Reminder limits
`define DKRA_KR_REPEATS      3
`define DKRA_KR_SPEED_KMH    3
`define DKRA_SMART_SPD_RST   5

// Register map (byte addresses)
`define DKRA_REG_CTRL        12'h000
`define DKRA_REG_STAT        12'h004

// Control register fields
`define DKRA_CTRL_EN_BIT     0
`define DKRA_CTRL_EN_RST     1'b1
`define DKRA_CTRL_THR_LSB    8
`define DKRA_CTRL_THR_MSB    15

// Status register fields
`define DKRA_STAT_LOCK_BIT   0
`define DKRA_STAT_UNLK_BIT   1
`define DKRA_STAT_PRI_LSB    4
`define DKRA_STAT_PRI_MSB    6
`define DKRA_STAT_ARMED_BIT  8
`define DKRA_STAT_KRON_BIT   9
`define DKRA_STAT_CNT_LSB    12
`define DKRA_STAT_CNT_MSB    13

`endif

// >>> design/dkra_pkg.sv
package dkra_pkg;

  // Lower code means higher rank; none sorts last by the explicit check
  typedef enum logic [2:0] {
    PRI_NONE, PRI_CRASH, PRI_AUTO, PRI_KR, PRI_CENTRAL
  } dkra_pri_t;

  typedef enum logic [1:0] {ARB_IDLE, ARB_DRIVE, ARB_GAP} dkra_arb_st_t;

  typedef enum logic [1:0] {KR_IDLE, KR_ASK, KR_ON, KR_OFF} dkra_kr_st_t;

endpackage : dkra_pkg

// >>> design/dkra_reminder_arbiter.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dkra_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Key in, driver locked, driver opens: unlock
// - Key in, passenger locked, passenger opens: unlock
// - Driver open and locked, key in: unlock
// - Passenger open and locked, key in: unlock
// - Both open, one locked, key in: unlock
// - Driver locks within 0.5 s of close
// - Passenger locks within 0.5 s of close
// - Still locked: three half-second unlock repeats
// - Key out, unlock or close aborts repeats
// - Exhausted reminder waits for a re-arm event
// - Speed 3 km/h or more blocks reminder
// - Smart-key command: 1 s, then repeats
// - Smart-key repeats stop on any key or front door change
// - Smart-key blocked above configured speed
// - Crash, auto, reminder, central priority order
// - Same rank, same direction: ignored
// - Same rank, opposite: stop, 100 ms gap
// - Higher rank preempts lower at once
// - 100 ms gap after completion, crash excepted
// - Door warning with front door open blocks locking
module dkra_reminder_arbiter #(
  parameter int unsigned TICK_CYC = `DKRA_MS_PS / `DKRA_CLK_PS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Door and key states received over CAN
  input  wire logic        key_in,
  input  wire logic        front_left_door_open,
  input  wire logic        front_right_door_open,
  input  wire logic        front_left_door_locked,
  input  wire logic        front_right_door_locked,
  input  wire logic        door_warn_sw,
  input  wire logic [7:0]  veh_speed,
  input  wire logic        smart_remind,
  // Requests from other door functions, one-cycle pulses
  input  wire logic        crash_req,
  input  wire logic        auto_req,
  input  wire logic        auto_lock,
  input  wire logic        central_req,
  input  wire logic        central_lock,
  // Actuator commands
  output logic             lock_out,
  output logic             unlock_out
);

  import dkra_pkg::*;

  localparam int TW = 13;

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic        kr_enable;
  logic [7:0]  smart_thr;
  wire         acc     = psel & penable;
  wire         hit_ctl = (paddr == `DKRA_REG_CTRL);
  wire         hit_sta = (paddr == `DKRA_REG_STAT);
  wire         wr_ctl  = acc & pwrite & hit_ctl;
  wire [31:0]  ctl_val;
  wire [31:0]  sta_val;
  wire [31:0]  rd_val  = hit_ctl ? ctl_val : (hit_sta ? sta_val : 32'h0000_0000);

  assign pready  = acc;
  assign pslverr = acc & ~hit_ctl & ~hit_sta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kr_enable <= `DKRA_CTRL_EN_RST;
      smart_thr <= 8'(`DKRA_SMART_SPD_RST);
      prdata    <= 32'h0000_0000;
    end else begin
      if (wr_ctl && pstrb[0])
        kr_enable <= pwdata[`DKRA_CTRL_EN_BIT];
      if (wr_ctl && pstrb[1])
        smart_thr <= pwdata[`DKRA_CTRL_THR_MSB:`DKRA_CTRL_THR_LSB];
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick and input edges

  logic ms_tick;

  dkra_tick #(.CYC(TICK_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick)
  );

  logic key_q;
  logic do_q;
  logic po_q;
  logic dl_q;
  logic pl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {key_q, do_q, po_q, dl_q, pl_q} <= 5'h0_0;
    end else begin
      key_q <= key_in;
      do_q  <= front_left_door_open;
      po_q  <= front_right_door_open;
      dl_q  <= front_left_door_locked;
      pl_q  <= front_right_door_locked;
    end
  end

  wire key_r   = key_in & ~key_q;
  wire key_f   = ~key_in & key_q;
  wire do_r    = front_left_door_open & ~do_q;
  wire do_f    = ~front_left_door_open & do_q;
  wire po_r    = front_right_door_open & ~po_q;
  wire po_f    = ~front_right_door_open & po_q;
  wire dl_r    = front_left_door_locked & ~dl_q;
  wire dl_f    = ~front_left_door_locked & dl_q;
  wire pl_r    = front_right_door_locked & ~pl_q;
  wire pl_f    = ~front_right_door_locked & pl_q;
  wire any_chg = key_r | key_f | do_r | do_f | po_r | po_f | dl_r | dl_f | pl_r | pl_f;
  wire locked  = front_left_door_locked | front_right_door_locked;

  // Half-second windows opened by each front door closing
  logic win_dl;
  logic win_pl;

  dkra_timer #(.W(TW)) u_win_dr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick),
    .load    (do_f),
    .clear   (1'b0),
    .value   (TW'(`DKRA_T_CLOSE_WIN_MS)),
    .busy    (win_dl),
    .done    ()
  );

  dkra_timer #(.W(TW)) u_win_pa (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick),
    .load    (po_f),
    .clear   (1'b0),
    .value   (TW'(`DKRA_T_CLOSE_WIN_MS)),
    .busy    (win_pl),
    .done    ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Reminder triggers

  dkra_kr_st_t kr_st;
  dkra_kr_st_t next_kr_st;
  logic        kr_armed;
  logic        kr_smart;
  logic        kr_first;
  logic [1:0]  kr_cnt;
  logic        kr_grant;
  logic        kr_done;
  dkra_pri_t   act_pri;

  wire kr_idle  = (kr_st == KR_IDLE);
  wire spd_hi   = (veh_speed >= 8'(`DKRA_KR_SPEED_KMH));
  wire smart_hi = (veh_speed > smart_thr);
  wire t1 = key_in & front_left_door_locked & do_r;
  wire t2 = key_in & front_right_door_locked & po_r;
  wire t3 = front_left_door_open & front_left_door_locked & key_r;
  wire t4 = front_right_door_open & front_right_door_locked & key_r;
  wire t5 = front_left_door_open & front_right_door_open & locked & key_r;
  wire t6 = key_in & dl_r & win_dl;
  wire t7 = key_in & pl_r & win_pl;
  wire key_trig = (t1 | t2 | t3 | t4 | t5 | t6 | t7) & kr_armed & ~spd_hi & kr_enable
                  & kr_idle;
  wire smart_trig = smart_remind & ~smart_hi & kr_enable & kr_idle & ~key_trig;
  wire rearm = do_f | po_f | key_f | dl_r | dl_f | pl_r | pl_f;

  // A closing door only aborts when it is the one that is locked
  wire key_abort = key_f | dl_f | pl_f | spd_hi
                   | (front_left_door_locked & do_f)
                   | (front_right_door_locked & po_f);
  wire smart_abort = any_chg | smart_hi;
  wire kr_abort    = ~kr_idle & (kr_smart ? smart_abort : key_abort);
  wire kr_last     = (kr_cnt == 2'(`DKRA_KR_REPEATS));
  wire kr_exhaust  = (kr_st == KR_ON) & kr_done & ~kr_abort & ~kr_first & kr_last
                     & locked;
  wire kr_go       = (kr_st == KR_ASK);
  wire [TW-1:0] kr_len = kr_first ? TW'(`DKRA_T_KR_FIRST_MS) : TW'(`DKRA_T_KR_HALF_MS);
  logic off_busy;
  logic off_done;

  dkra_timer #(.W(TW)) u_kr_off (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick),
    .load    ((kr_st == KR_ON) & kr_done),
    .clear   (kr_abort),
    .value   (TW'(`DKRA_T_KR_HALF_MS)),
    .busy    (off_busy),
    .done    (off_done)
  );

  always_comb begin
    next_kr_st = kr_st;
    case (kr_st)
      KR_IDLE: if (key_trig || smart_trig) next_kr_st = KR_ASK;
      KR_ASK:  if (kr_grant) next_kr_st = KR_ON;
      KR_ON: begin
        if (kr_done)
          next_kr_st = (locked && !kr_last) ? KR_OFF : KR_IDLE;
        else if (act_pri != PRI_KR)
          next_kr_st = KR_IDLE;
      end
      KR_OFF:  if (off_done) next_kr_st = KR_ASK;
      default: next_kr_st = KR_IDLE;
    endcase
    if (kr_abort)
      next_kr_st = KR_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kr_st    <= KR_IDLE;
      kr_armed <= 1'b1;
      kr_smart <= 1'b0;
      kr_first <= 1'b0;
      kr_cnt   <= 2'h0;
    end else begin
      kr_st <= next_kr_st;
      if (kr_exhaust)
        kr_armed <= 1'b0;
      else if (rearm)
        kr_armed <= 1'b1;
      if (kr_idle) begin
        kr_smart <= smart_trig;
        kr_first <= 1'b1;
        kr_cnt   <= 2'h0;
      end else if (kr_grant) begin
        kr_first <= 1'b0;
        kr_cnt   <= kr_first ? kr_cnt : kr_cnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output arbiter

  dkra_arb_st_t st;
  dkra_arb_st_t next_st;
  logic         act_lock;
  dkra_pri_t    slot_pri;
  logic         slot_lock;
  logic [TW-1:0] slot_len;
  logic         pulse_done;
  logic         gap_busy;
  logic         gap_done;

  wire lock_inh = door_warn_sw & (front_left_door_open | front_right_door_open);
  wire auto_ok  = auto_req & ~(auto_lock & lock_inh);
  wire cent_ok  = central_req & ~(central_lock & lock_inh);

  // Fixed rank: crash, auto, reminder, central
  wire dkra_pri_t     c_pri  = crash_req ? PRI_CRASH : auto_ok ? PRI_AUTO
                               : kr_go ? PRI_KR : cent_ok ? PRI_CENTRAL : PRI_NONE;
  wire                c_lock = crash_req ? 1'b0 : auto_ok ? auto_lock
                               : kr_go ? 1'b0 : central_lock;
  wire [TW-1:0]       c_len  = crash_req ? TW'(`DKRA_T_CRASH_MS)
                               : auto_ok ? TW'(`DKRA_T_AUTO_MS)
                               : kr_go ? kr_len : TW'(`DKRA_T_CENTRAL_MS);

  // A parked request lapses once the reminder gives up, or if it locks under door warning
  wire dkra_pri_t     s_pri  = ((slot_pri == PRI_KR && !kr_go) || (slot_lock && lock_inh))
                               ? PRI_NONE : slot_pri;
  wire                c_win  = (c_pri != PRI_NONE) && (s_pri == PRI_NONE || c_pri < s_pri);
  wire dkra_pri_t     b_pri  = c_win ? c_pri : s_pri;
  wire                b_lock = c_win ? c_lock : slot_lock;
  wire [TW-1:0]       b_len  = c_win ? c_len : slot_len;
  wire                b_any  = (b_pri != PRI_NONE);

  wire drv     = (st == ARB_DRIVE);
  wire preempt = drv & b_any & (b_pri < act_pri);
  wire opp     = drv & (c_pri == act_pri) & (c_lock != act_lock);
  wire kr_stop = drv & (act_pri == PRI_KR) & kr_abort;
  wire to_gap  = drv & ~preempt & (opp | kr_stop | pulse_done);
  wire start   = preempt
               | ((st == ARB_IDLE) & b_any)
               | ((st == ARB_GAP) & ((b_pri == PRI_CRASH) | (gap_done & b_any)));

  assign kr_grant = start & (b_pri == PRI_KR);
  assign kr_done  = drv & pulse_done & ~preempt & ~opp & (act_pri == PRI_KR);

  dkra_timer #(.W(TW)) u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick),
    .load    (start),
    .clear   (to_gap),
    .value   (b_len),
    .busy    (),
    .done    (pulse_done)
  );

  dkra_timer #(.W(TW)) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick),
    .load    (to_gap),
    .clear   (start),
    .value   (TW'(`DKRA_T_GAP_MS)),
    .busy    (gap_busy),
    .done    (gap_done)
  );

  always_comb begin
    next_st = st;
    case (st)
      ARB_IDLE:  if (start) next_st = ARB_DRIVE;
      ARB_DRIVE: if (to_gap) next_st = ARB_GAP;
      ARB_GAP: begin
        if (start)
          next_st = ARB_DRIVE;
        else if (!gap_busy)
          next_st = ARB_IDLE;
      end
      default:   next_st = ARB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= ARB_IDLE;
      act_pri    <= PRI_NONE;
      act_lock   <= 1'b0;
      slot_pri   <= PRI_NONE;
      slot_lock  <= 1'b0;
      slot_len   <= '0;
      lock_out   <= 1'b0;
      unlock_out <= 1'b0;
    end else begin
      st <= next_st;
      if (start) begin
        act_pri    <= b_pri;
        act_lock   <= b_lock;
        lock_out   <= b_lock;
        unlock_out <= ~b_lock;
        slot_pri   <= PRI_NONE;
      end else if (to_gap) begin
        act_pri    <= PRI_NONE;
        lock_out   <= 1'b0;
        unlock_out <= 1'b0;
        slot_pri   <= opp ? c_pri : PRI_NONE;
        slot_lock  <= c_lock;
        slot_len   <= c_len;
      end else if (st == ARB_GAP) begin
        slot_pri   <= b_pri;
        slot_lock  <= b_lock;
        slot_len   <= b_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register views

  assign ctl_val = {16'h0000, smart_thr, 7'h00, kr_enable};
  assign sta_val = {18'h0_0000, kr_cnt, 2'h0, ~kr_idle, kr_armed, 1'b0, act_pri,
                    2'h0, unlock_out, lock_out};

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_drive_same;
    drv && c_pri == act_pri && c_lock == act_lock && !pulse_done && !kr_stop;
  endsequence

  sequence s_gap_run;
    st == ARB_GAP && !lock_out && !unlock_out;
  endsequence

  property p_crash_now;
    crash_req && !(drv && act_pri == PRI_CRASH) |=> unlock_out && act_pri == PRI_CRASH;
  endproperty
  a_crash_now: assert property (p_crash_now) else $error("crash unlock not immediate");

  property p_same_ignore;
    s_drive_same |=> $stable(act_pri) && $stable(lock_out) && $stable(unlock_out);
  endproperty
  a_same_ignore: assert property (p_same_ignore) else $error("same request disturbed");

  property p_opp_gap;
    opp && !preempt |=> s_gap_run ##1 (st != ARB_DRIVE || $past(gap_done));
  endproperty
  a_opp_gap: assert property (p_opp_gap) else $error("opposite request no gap");

  property p_preempt;
    preempt |=> drv && act_pri == $past(b_pri) && lock_out == $past(b_lock);
  endproperty
  a_preempt: assert property (p_preempt) else $error("higher rank not taken");

  property p_gap_after;
    drv && pulse_done && !preempt |=> s_gap_run;
  endproperty
  a_gap_after: assert property (p_gap_after) else $error("no gap after output");

  property p_gap_hold;
    st == ARB_GAP && gap_busy && !gap_done && b_pri != PRI_CRASH |=> !lock_out && !unlock_out;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("output inside gap");

  property p_abort;
    kr_stop && !preempt |=> !unlock_out && kr_st == KR_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("reminder not aborted");

  property p_exhaust;
    kr_exhaust |=> !kr_armed && kr_st == KR_IDLE;
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("reminder not disarmed");

  wire kr_smart_start = smart_trig;
  property p_speed;
    kr_idle && next_kr_st == KR_ASK |-> (kr_smart_start ? !smart_hi : !spd_hi);
  endproperty
  a_speed: assert property (p_speed) else $error("reminder above speed");

  property p_door_open;
    t1 && kr_armed && kr_idle && kr_enable && !spd_hi |=> kr_go
      ##1 (kr_st == KR_ON ? unlock_out : (kr_go || $past(kr_abort)));
  endproperty
  a_door_open: assert property (p_door_open) else $error("driver door reminder missed");

  property p_lock_inh;
    $rose(lock_out) |-> !$past(lock_inh);
  endproperty
  a_lock_inh: assert property (p_lock_inh) else $error("lock under door warning");

  property p_repeats;
    kr_grant && !kr_first |-> kr_cnt < 2'(`DKRA_KR_REPEATS);
  endproperty
  a_repeats: assert property (p_repeats) else $error("too many repeats");

endmodule : dkra_reminder_arbiter

`default_nettype wire

// >>> design/dkra_tick.sv
`timescale 1ns/1ps
`default_nettype none

module dkra_tick #(
  parameter int unsigned CYC = 250000
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Millisecond enable
  output logic      tick
);

  localparam int W = $clog2(CYC);

  logic [W-1:0] cnt;
  wire          wrap = (cnt == W'(CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? '0 : cnt + 1'b1;
      tick <= wrap;
    end
  end

endmodule : dkra_tick

`default_nettype wire

// >>> design/dkra_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dkra_timer #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         clear,
  input  wire logic [W-1:0] value,
  // State
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt;

  // Length is value ticks, so the first partial tick costs under 1 ms
  assign busy = (cnt != '0);
  // Done ignores load and clear, which are built from it upstream
  assign done = tick & (cnt == W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= '0;
    else if (clear)
      cnt <= '0;
    else if (load)
      cnt <= value;
    else if (tick && busy)
      cnt <= cnt - 1'b1;
  end

endmodule : dkra_timer

`default_nettype wire

// >>> tb/dkra_act_model.sv
`timescale 1ns/1ps
`default_nettype none

// Actuator side: counts command pulses and keeps the last pulse length
module dkra_act_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Actuator commands
  input  wire logic lock_out,
  input  wire logic unlock_out,
  // Observations
  output int        unlock_pulses,
  output int        lock_pulses,
  output int        last_len
);
  int run;

  // Length is in clock cycles; the bench scales its millisecond limits to cycles by MS
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_pulses <= 0;
      lock_pulses   <= 0;
      last_len      <= 0;
      run           <= 0;
    end else begin
      if ($rose(unlock_out)) unlock_pulses <= unlock_pulses + 1;
      if ($rose(lock_out)) lock_pulses <= lock_pulses + 1;
      // A direct handover to the other output starts a new length
      if ($rose(unlock_out) || $rose(lock_out)) begin
        if (run != 0) last_len <= run;
        run <= 1;
      end else if (lock_out || unlock_out) begin
        run <= run + 1;
      end else if (run != 0) begin
        last_len <= run;
        run      <= 0;
      end
    end
  end
endmodule : dkra_act_model

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // Short millisecond keeps the run brief
  localparam int MS = 4;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel, penable, pwrite;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, er;
  logic        key_in, fl_open, fr_open, fl_locked, fr_locked, door_warn_sw;
  logic [7:0]  veh_speed;
  logic        smart_remind, crash_req, auto_req, auto_lock, central_req, central_lock;
  logic        lock_out, unlock_out;
  int          unlock_pulses, lock_pulses, last_len;
  int          errors, checks_done, n, u0;

  dkra_reminder_arbiter #(.TICK_CYC(MS)) dkra_reminder_arbiter_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_in(key_in), .front_left_door_open(fl_open),
    .front_right_door_open(fr_open), .front_left_door_locked(fl_locked),
    .front_right_door_locked(fr_locked), .door_warn_sw(door_warn_sw),
    .veh_speed(veh_speed), .smart_remind(smart_remind), .crash_req(crash_req),
    .auto_req(auto_req), .auto_lock(auto_lock), .central_req(central_req),
    .central_lock(central_lock), .lock_out(lock_out), .unlock_out(unlock_out));

  dkra_act_model dkra_act_model_i (
    .pclk(pclk), .presetn(presetn), .lock_out(lock_out), .unlock_out(unlock_out),
    .unlock_pulses(unlock_pulses), .lock_pulses(lock_pulses), .last_len(last_len));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic in_rng(input string nm, input int v, input int lo, input int hi);
    check(nm, 32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask : in_rng

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int which, input logic dir);
    @(posedge pclk);
    auto_lock    <= dir;
    central_lock <= dir;
    case (which)
      0: crash_req <= 1'b1;
      1: auto_req <= 1'b1;
      2: central_req <= 1'b1;
      default: smart_remind <= 1'b1;
    endcase
    @(posedge pclk);
    {crash_req, auto_req, central_req, smart_remind} <= '0;
  endtask : pulse

  // Cycles until the chosen output reaches the level, capped at lim
  task automatic wait_lvl(input logic lk, input logic lvl, input int lim);
    n = 0;
    while (((lk ? lock_out : unlock_out) !== lvl) && n < lim) begin
      @(negedge pclk);
      n++;
    end
    // Let the model latch a pulse that has just ended
    @(negedge pclk);
  endtask : wait_lvl

  task automatic idle(input int ms);
    repeat (ms * MS) @(posedge pclk);
  endtask : idle

  task automatic calm();
    @(posedge pclk);
    {key_in, fl_open, fr_open, fl_locked, fr_locked, door_warn_sw} <= '0;
    veh_speed <= 8'h00;
    idle(300);
  endtask : calm

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("ctrl_reset", rd, 32'h0000_0501);
    apb(1'b1, 12'h000, 32'h0000_0a01);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("ctrl_thr", rd, 32'h0000_0a01);
    apb(1'b1, 12'h000, 32'h0000_0501);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("unmapped_err", {31'h0, er}, 32'h0000_0001);
    check("unmapped_data", rd, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_key_open();
    @(posedge pclk);
    key_in    <= 1'b1;
    fl_locked <= 1'b1;
    idle(10);
    u0 = unlock_pulses;
    fl_open <= 1'b1;
    wait_lvl(1'b0, 1'b1, 20);
    in_rng("kr_start", n, 1, 4);
    wait_lvl(1'b0, 1'b0, 1100 * MS);
    in_rng("kr_first_len", last_len, 999 * MS, 1001 * MS);
    idle(3100);
    check("kr_repeats", unlock_pulses - u0, 4);
    in_rng("kr_rep_len", last_len, 499 * MS, 501 * MS);
    idle(1000);
    check("kr_no_rerun", unlock_pulses - u0, 4);
    calm();
    $display("test key_open done");
  endtask : t_key_open

  task automatic t_abort();
    @(posedge pclk);
    key_in    <= 1'b1;
    fr_locked <= 1'b1;
    idle(10);
    u0 = unlock_pulses;
    fr_open <= 1'b1;
    wait_lvl(1'b0, 1'b1, 20);
    wait_lvl(1'b0, 1'b0, 1100 * MS);
    wait_lvl(1'b0, 1'b1, 600 * MS);
    idle(100);
    fr_locked <= 1'b0;
    wait_lvl(1'b0, 1'b0, 3);
    in_rng("abort_now", n, 1, 3);
    idle(1500);
    check("abort_count", unlock_pulses - u0, 2);
    calm();
    $display("test abort done");
  endtask : t_abort

  task automatic t_speed();
    @(posedge pclk);
    veh_speed <= 8'h03;
    fl_open   <= 1'b1;
    fl_locked <= 1'b1;
    idle(10);
    key_in <= 1'b1;
    wait_lvl(1'b0, 1'b1, 1200 * MS);
    check("speed_block", {31'h0, unlock_out}, 32'h0000_0000);
    calm();
    $display("test speed done");
  endtask : t_speed

  task automatic t_arbiter();
    pulse(2, 1'b1);
    wait_lvl(1'b1, 1'b1, 4);
    idle(100);
    pulse(0, 1'b0);
    wait_lvl(1'b0, 1'b1, 4);
    in_rng("crash_now", n, 1, 2);
    check("crash_wins", {31'h0, lock_out}, 32'h0000_0000);
    wait_lvl(1'b0, 1'b0, 5100 * MS);
    in_rng("crash_len", last_len, 4999 * MS, 5001 * MS);
    idle(200);
    pulse(2, 1'b1);
    wait_lvl(1'b1, 1'b1, 4);
    idle(50);
    pulse(2, 1'b0);
    wait_lvl(1'b1, 1'b0, 3);
    in_rng("opp_stop", n, 0, 2);
    wait_lvl(1'b0, 1'b1, 110 * MS);
    in_rng("opp_gap", n, 99 * MS - 2, 101 * MS + 2);
    wait_lvl(1'b0, 1'b0, 600 * MS);
    pulse(1, 1'b1);
    wait_lvl(1'b1, 1'b1, 110 * MS);
    in_rng("done_gap", n, 98 * MS - 2, 101 * MS + 2);
    idle(100);
    pulse(1, 1'b1);
    wait_lvl(1'b1, 1'b0, 600 * MS);
    in_rng("same_dir_len", last_len, 499 * MS, 501 * MS);
    $display("test arbiter done");
  endtask : t_arbiter

  task automatic t_warn();
    idle(200);
    @(posedge pclk);
    door_warn_sw <= 1'b1;
    fl_open      <= 1'b1;
    pulse(2, 1'b1);
    wait_lvl(1'b1, 1'b1, 700 * MS);
    check("warn_block", {31'h0, lock_out}, 32'h0000_0000);
    calm();
    $display("test warn done");
  endtask : t_warn

  task automatic t_smart();
    @(posedge pclk);
    fr_locked <= 1'b1;
    veh_speed <= 8'h06;
    idle(10);
    u0 = unlock_pulses;
    pulse(3, 1'b0);
    idle(20);
    check("smart_speed", unlock_pulses - u0, 0);
    veh_speed <= 8'h00;
    idle(10);
    pulse(3, 1'b0);
    wait_lvl(1'b0, 1'b1, 4);
    in_rng("smart_start", n, 1, 3);
    wait_lvl(1'b0, 1'b0, 1100 * MS);
    in_rng("smart_len", last_len, 999 * MS, 1001 * MS);
    idle(200);
    fr_locked <= 1'b0;
    idle(1500);
    check("smart_abort", unlock_pulses - u0, 1);
    calm();
    $display("test smart done");
  endtask : t_smart

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole sequence needs about 85000 cycles
  initial begin
    repeat (95000) @(posedge pclk);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {key_in, fl_open, fr_open, fl_locked, fr_locked, door_warn_sw} = '0;
    veh_speed = 8'h00;
    {smart_remind, crash_req, auto_req, auto_lock, central_req, central_lock} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_key_open();
    t_abort();
    t_speed();
    t_arbiter();
    t_warn();
    t_smart();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
